// ==== hdl/io_range_decoder.sv ====
// The strobed register port is this design's own decision.
`timescale 1ns/1ns
`default_nettype none
module io_range_decoder
  import io_range_pkg::*;
(
  input  wire logic                  clock_in,
  input  wire logic                  rst_n_in,
  // register port
  input  wire logic [ADDR_WIDTH-1:0] reg_addr_in,
  input  wire logic [DATA_WIDTH-1:0] reg_wdata_in,
  input  wire logic                  reg_write_in,
  input  wire logic                  reg_read_in,
  output logic      [DATA_WIDTH-1:0] reg_rdata_out,
  // cpu cycle
  input  wire logic [15:0]           cpu_addr_in,
  input  wire logic                  cpu_io_cycle_in,
  input  wire logic                  cpu_read_in,
  input  wire logic                  cpu_write_in,
  // isa master cycle
  input  wire logic [15:0]           isa_addr_in,
  input  wire logic                  isa_io_cycle_in,
  input  wire logic                  isa_read_in,
  input  wire logic                  isa_write_in,
  // decode outputs
  output logic      [1:0]            io_range_select_out,
  output logic                       local_device_claim_out
);

  logic       rst_sync1_q;
  logic       rst_sync2_q;
  logic       rst_n;

  logic [7:0] base_low_q  [NUM_RANGES];
  logic [7:0] base_high_q [NUM_RANGES];
  logic [7:0] size_mask_q [NUM_RANGES];
  logic [7:0] config_q    [NUM_RANGES];

  logic [1:0] cpu_hit;
  logic [1:0] isa_hit;
  logic [1:0] select_d;
  logic [1:0] select_q;
  logic [1:0] claim_d;
  logic       claim_q;
  logic [7:0] rdata_q;

  // reset release through two flops
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_sync1_q <= 1'b0;
      rst_sync2_q <= 1'b0;
    end else begin
      rst_sync1_q <= 1'b1;
      rst_sync2_q <= rst_sync1_q;
    end
  end
  assign rst_n = rst_sync2_q;

  genvar g;
  generate
    for (g = 0; g < NUM_RANGES; g++) begin : g_range
      localparam logic [7:0] OFS = 8'(g * int'(RANGE_STRIDE));
      logic sel_any;
      logic cpu_rw_ok;
      logic isa_rw_ok;
      logic cpu_stb_ok;
      logic isa_stb_ok;
      logic [15:0] ref_care;
      logic [15:0] ref_base;
      logic        ref_cpu_hit;
      logic        ref_isa_hit;

      // register writes; both ranges share one layout
      always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
          base_low_q[g]  <= REG_RESET;
          base_high_q[g] <= REG_RESET;
          size_mask_q[g] <= REG_RESET;
          config_q[g]    <= REG_RESET;
        end else if (reg_write_in) begin
          if (reg_addr_in == RANGE0_BASE_LOW + OFS) begin
            base_low_q[g] <= reg_wdata_in;
          end else if (reg_addr_in == RANGE0_BASE_HIGH + OFS) begin
            base_high_q[g] <= reg_wdata_in;
          end else if (reg_addr_in == RANGE0_SIZE_MASK + OFS) begin
            size_mask_q[g] <= reg_wdata_in;
          end else if (reg_addr_in == RANGE0_CONFIG + OFS) begin
            config_q[g] <= reg_wdata_in;
          end
        end
      end

      io_range_match u_cpu_match (
        .base_low_in  (base_low_q[g]),
        .base_high_in (base_high_q[g]),
        .size_mask_in (size_mask_q[g]),
        .io_addr_in   (cpu_addr_in),
        .hit_out      (cpu_hit[g])
      );

      io_range_match u_isa_match (
        .base_low_in  (base_low_q[g]),
        .base_high_in (base_high_q[g]),
        .size_mask_in (size_mask_q[g]),
        .io_addr_in   (isa_addr_in),
        .hit_out      (isa_hit[g])
      );

      // bits 4/5 pick which cycle kinds may select
      assign sel_any    = config_q[g][CFG_READ_BIT] | config_q[g][CFG_WRITE_BIT];
      assign cpu_rw_ok  = (config_q[g][CFG_READ_BIT]  & cpu_read_in) |
                          (config_q[g][CFG_WRITE_BIT] & cpu_write_in);
      assign isa_rw_ok  = (config_q[g][CFG_READ_BIT]  & isa_read_in) |
                          (config_q[g][CFG_WRITE_BIT] & isa_write_in);
      // strobe mode gates with live strobe, chip select mode with cycle kind
      assign cpu_stb_ok = config_q[g][CFG_STROBE_BIT] ? cpu_rw_ok
                                                      : (sel_any & (cpu_read_in | cpu_write_in) & cpu_rw_ok);
      assign isa_stb_ok = config_q[g][CFG_STROBE_BIT] ? isa_rw_ok
                                                      : (sel_any & (isa_read_in | isa_write_in) & isa_rw_ok);

      // zero config leaves everything inactive since every term needs a set bit
      assign select_d[g] = (cpu_io_cycle_in & cpu_hit[g] & cpu_stb_ok) |
                           (config_q[g][CFG_MASTER_BIT] & isa_io_cycle_in &
                            isa_hit[g] & isa_stb_ok);
      assign claim_d[g]  = config_q[g][CFG_LOCAL_BIT] & cpu_io_cycle_in & cpu_hit[g];

      // line-by-line view of the ignore rules, kept apart from the comparator it checks
      always_comb begin
        ref_care = 16'hffff;
        for (int b = 0; b < 7; b++) begin
          if (b < int'(size_mask_q[g][SIZE_MSB:SIZE_LSB])) begin
            ref_care[b] = 1'b0;
          end
        end
        for (int m = 0; m < 4; m++) begin
          if (size_mask_q[g][MASK_A7_BIT + m]) begin
            ref_care[7 + m] = 1'b0;
          end
        end
        if (size_mask_q[g][MASK_UPPER_BIT]) begin
          ref_care[15:11] = 5'h00;
        end
      end
      assign ref_base    = {base_high_q[g], base_low_q[g]};
      assign ref_cpu_hit = (cpu_addr_in & ref_care) == (ref_base & ref_care);
      assign ref_isa_hit = (isa_addr_in & ref_care) == (ref_base & ref_care);

      // per-range checks
      AST_CPU_MATCH: assert property (@(posedge clock_in) disable iff (!rst_n)
        cpu_hit[g] == ref_cpu_hit)
        else $error("cpu match differs from size and mask fields");

      AST_ISA_MATCH: assert property (@(posedge clock_in) disable iff (!rst_n)
        isa_hit[g] == ref_isa_hit)
        else $error("isa match differs from size and mask fields");

      AST_READ_OFF: assert property (@(posedge clock_in) disable iff (!rst_n)
        (!config_q[g][CFG_READ_BIT] && !cpu_write_in && !isa_write_in) |=> !select_q[g])
        else $error("select on a read while reads disabled");

      AST_WRITE_ON: assert property (@(posedge clock_in) disable iff (!rst_n)
        (cpu_io_cycle_in && cpu_write_in && cpu_hit[g] && config_q[g][CFG_WRITE_BIT]) |=> select_q[g])
        else $error("write select missing");

      AST_MASTER_ON: assert property (@(posedge clock_in) disable iff (!rst_n)
        (isa_io_cycle_in && isa_read_in && isa_hit[g] && config_q[g][CFG_MASTER_BIT] &&
         config_q[g][CFG_READ_BIT]) |=> select_q[g])
        else $error("isa master select missing");

      AST_STROBE_GATE: assert property (@(posedge clock_in) disable iff (!rst_n)
        (config_q[g][CFG_STROBE_BIT] && !cpu_read_in && !cpu_write_in && !isa_read_in && !isa_write_in)
        |=> !select_q[g])
        else $error("strobe mode select without a strobe");

      AST_ADDR_MODE: assert property (@(posedge clock_in) disable iff (!rst_n)
        (!config_q[g][CFG_STROBE_BIT] && cpu_io_cycle_in && cpu_read_in && cpu_hit[g] &&
         config_q[g][CFG_READ_BIT]) |=> select_q[g])
        else $error("chip select mode select missing");

      AST_NO_HIT: assert property (@(posedge clock_in) disable iff (!rst_n)
        (!cpu_hit[g] && !isa_hit[g]) |=> !select_q[g])
        else $error("select without an address match");

      AST_RESERVED_ONLY: assert property (@(posedge clock_in) disable iff (!rst_n)
        (config_q[g][CFG_STROBE_BIT:CFG_LOCAL_BIT] == 5'h00) |=> !select_q[g])
        else $error("select from reserved config bits");

      AST_LOW_STORE: assert property (@(posedge clock_in) disable iff (!rst_n)
        (reg_write_in && reg_addr_in == RANGE0_BASE_LOW + OFS) |=> (base_low_q[g] == $past(reg_wdata_in)))
        else $error("base low not stored");

      AST_HIGH_STORE: assert property (@(posedge clock_in) disable iff (!rst_n)
        (reg_write_in && reg_addr_in == RANGE0_BASE_HIGH + OFS) |=> (base_high_q[g] == $past(reg_wdata_in)))
        else $error("base high not stored");

      AST_SIZE_STORE: assert property (@(posedge clock_in) disable iff (!rst_n)
        (reg_write_in && reg_addr_in == RANGE0_SIZE_MASK + OFS) |=> (size_mask_q[g] == $past(reg_wdata_in)))
        else $error("size and mask not stored");

      AST_CFG_STORE: assert property (@(posedge clock_in) disable iff (!rst_n)
        (reg_write_in && reg_addr_in == RANGE0_CONFIG + OFS) |=> (config_q[g] == $past(reg_wdata_in)))
        else $error("config not stored");

      AST_LOW_READ: assert property (@(posedge clock_in) disable iff (!rst_n)
        (reg_read_in && reg_addr_in == RANGE0_BASE_LOW + OFS) |=> (reg_rdata_out == $past(base_low_q[g])))
        else $error("base low read back wrong");

      AST_HIGH_READ: assert property (@(posedge clock_in) disable iff (!rst_n)
        (reg_read_in && reg_addr_in == RANGE0_BASE_HIGH + OFS) |=> (reg_rdata_out == $past(base_high_q[g])))
        else $error("base high read back wrong");

      AST_RESET_CLEAR: assert property (@(posedge clock_in)
        !rst_n |=> (base_low_q[g] == REG_RESET && base_high_q[g] == REG_RESET &&
                    size_mask_q[g] == REG_RESET && config_q[g] == REG_RESET))
        else $error("decoder register not cleared by reset");
    end
  endgenerate

  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      select_q <= 2'h0;
    end else begin
      select_q <= select_d;
    end
  end

  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      claim_q <= 1'b0;
    end else begin
      claim_q <= |claim_d;
    end
  end

  // read data one cycle after the read strobe; unmapped reads zero
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= 8'h00;
    end else if (reg_read_in) begin
      if (reg_addr_in == RANGE0_BASE_LOW) begin
        rdata_q <= base_low_q[0];
      end else if (reg_addr_in == RANGE0_BASE_HIGH) begin
        rdata_q <= base_high_q[0];
      end else if (reg_addr_in == RANGE0_SIZE_MASK) begin
        rdata_q <= size_mask_q[0];
      end else if (reg_addr_in == RANGE0_CONFIG) begin
        rdata_q <= config_q[0];
      end else if (reg_addr_in == RANGE1_BASE_LOW) begin
        rdata_q <= base_low_q[1];
      end else if (reg_addr_in == RANGE1_BASE_HIGH) begin
        rdata_q <= base_high_q[1];
      end else if (reg_addr_in == RANGE1_SIZE_MASK) begin
        rdata_q <= size_mask_q[1];
      end else if (reg_addr_in == RANGE1_CONFIG) begin
        rdata_q <= config_q[1];
      end else begin
        rdata_q <= 8'h00;
      end
    end else begin
      rdata_q <= 8'h00;
    end
  end

  assign reg_rdata_out          = rdata_q;
  assign io_range_select_out    = select_q;
  assign local_device_claim_out = claim_q;

  // assertions
  AST_ZERO_CFG_QUIET: assert property (@(posedge clock_in) disable iff (!rst_n)
    (config_q[0] == 8'h00) |=> !select_q[0])
    else $error("range 0 selected with zero config");

  AST_NO_MEM_SELECT: assert property (@(posedge clock_in) disable iff (!rst_n)
    (!cpu_io_cycle_in && !isa_io_cycle_in) |=> (select_q == 2'h0))
    else $error("select without an I/O cycle");

  AST_CLAIM_LOCAL: assert property (@(posedge clock_in) disable iff (!rst_n)
    (config_q[1][CFG_LOCAL_BIT] && cpu_io_cycle_in && cpu_hit[1]) |=> claim_q)
    else $error("local claim missing");

  AST_CLAIM_OFF: assert property (@(posedge clock_in) disable iff (!rst_n)
    (!config_q[0][CFG_LOCAL_BIT] && !config_q[1][CFG_LOCAL_BIT]) |=> !claim_q)
    else $error("claim without local bit");

  AST_READ_ENABLE: assert property (@(posedge clock_in) disable iff (!rst_n)
    (cpu_io_cycle_in && cpu_read_in && !cpu_write_in && cpu_hit[0] &&
     config_q[0][CFG_READ_BIT] && !isa_io_cycle_in) |=> select_q[0])
    else $error("read select missing");

  AST_WRITE_DISABLE: assert property (@(posedge clock_in) disable iff (!rst_n)
    (cpu_write_in && !cpu_read_in && !config_q[0][CFG_WRITE_BIT] &&
     !isa_io_cycle_in) |=> !select_q[0])
    else $error("write select while disabled");

  AST_MASTER_GATE: assert property (@(posedge clock_in) disable iff (!rst_n)
    (!cpu_io_cycle_in && !config_q[1][CFG_MASTER_BIT]) |=> !select_q[1])
    else $error("isa master select while disallowed");

  AST_WRITE_STORE: assert property (@(posedge clock_in) disable iff (!rst_n)
    (reg_write_in && reg_addr_in == RANGE1_BASE_LOW) |=> (base_low_q[1] == $past(reg_wdata_in)))
    else $error("base low not stored");

  AST_READ_BACK: assert property (@(posedge clock_in) disable iff (!rst_n)
    (reg_read_in && !reg_write_in && reg_addr_in == RANGE0_CONFIG) |=> (reg_rdata_out == $past(config_q[0])))
    else $error("config read back wrong");

  AST_CLAIM_CPU_ONLY: assert property (@(posedge clock_in) disable iff (!rst_n)
    !cpu_io_cycle_in |=> !claim_q)
    else $error("claim without a cpu i/o cycle");

  AST_CLAIM_RANGE0: assert property (@(posedge clock_in) disable iff (!rst_n)
    (config_q[0][CFG_LOCAL_BIT] && cpu_io_cycle_in && cpu_hit[0]) |=> claim_q)
    else $error("local claim missing on range 0");

  AST_ZERO_CFG_ALL: assert property (@(posedge clock_in) disable iff (!rst_n)
    (config_q[0] == 8'h00 && config_q[1] == 8'h00) |=> (!claim_q && select_q == 2'h0))
    else $error("output active with both configs zero");

  COV_CPU_SELECT: cover property (@(posedge clock_in) disable iff (!rst_n) select_q[0]);
  COV_ISA_SELECT: cover property (@(posedge clock_in) disable iff (!rst_n)
    isa_io_cycle_in && !cpu_io_cycle_in ##1 select_q[0]);
  COV_CLAIM: cover property (@(posedge clock_in) disable iff (!rst_n) claim_q);
  COV_STROBE_MODE: cover property (@(posedge clock_in) disable iff (!rst_n) select_q[0] && config_q[0][CFG_STROBE_BIT]);
  COV_RANGE1_SELECT: cover property (@(posedge clock_in) disable iff (!rst_n) select_q[1]);

endmodule : io_range_decoder
`default_nettype wire

// ==== hdl/io_range_match.sv ====
`timescale 1ns/1ns
`default_nettype none
// one range comparator: base, size and mask against a 16-bit port address
module io_range_match
  import io_range_pkg::*;
(
  input  wire logic [7:0]  base_low_in,
  input  wire logic [7:0]  base_high_in,
  input  wire logic [7:0]  size_mask_in,
  input  wire logic [15:0] io_addr_in,
  output logic             hit_out
);

  logic [15:0] care;
  logic [15:0] base;
  logic [6:0]  size_ignore;

  assign base = {base_high_in, base_low_in};

  // low 2^n ports ignored, n from the size field
  assign size_ignore = 7'((8'h01 << size_mask_in[SIZE_MSB:SIZE_LSB]) - 8'h01);

  always_comb begin
    care[6:0]   = ~size_ignore;
    care[10:7]  = ~size_mask_in[MASK_A10_BIT:MASK_A7_BIT];
    care[15:11] = {5{~size_mask_in[MASK_UPPER_BIT]}};
  end

  assign hit_out = ((io_addr_in ^ base) & care) == 16'h0000;

endmodule : io_range_match
`default_nettype wire

// ==== hdl/io_range_pkg.sv ====
package io_range_pkg;

  localparam int          ADDR_WIDTH        = 8;
  localparam int          DATA_WIDTH        = 8;
  localparam int          IO_ADDR_WIDTH     = 16;
  localparam int          NUM_RANGES        = 2;

  // register index of range 0; range 1 follows at +4
  localparam logic [7:0]  RANGE0_BASE_LOW   = 8'h28;
  localparam logic [7:0]  RANGE0_BASE_HIGH  = 8'h29;
  localparam logic [7:0]  RANGE0_SIZE_MASK  = 8'h2a;
  localparam logic [7:0]  RANGE0_CONFIG     = 8'h2b;
  localparam logic [7:0]  RANGE1_BASE_LOW   = 8'h2c;
  localparam logic [7:0]  RANGE1_BASE_HIGH  = 8'h2d;
  localparam logic [7:0]  RANGE1_SIZE_MASK  = 8'h2e;
  localparam logic [7:0]  RANGE1_CONFIG     = 8'h2f;
  localparam logic [7:0]  RANGE_STRIDE      = 8'h04;

  localparam logic [7:0]  REG_RESET         = 8'h00;

  // size/mask field positions
  localparam int          SIZE_LSB          = 0;
  localparam int          SIZE_MSB          = 2;
  localparam int          MASK_A7_BIT       = 3;
  localparam int          MASK_A10_BIT      = 6;
  localparam int          MASK_UPPER_BIT    = 7;

  // config field positions
  localparam int          CFG_LOCAL_BIT     = 3;
  localparam int          CFG_READ_BIT      = 4;
  localparam int          CFG_WRITE_BIT     = 5;
  localparam int          CFG_MASTER_BIT    = 6;
  localparam int          CFG_STROBE_BIT    = 7;

endpackage : io_range_pkg

// ==== testbench/io_bus_model.sv ====
`timescale 1ns/1ns
`default_nettype none
// cpu and isa master model: each i/o cycle is held for three clocks, select and claim are sampled by this model after the second
module io_bus_model (
  input  wire logic        clock_in,
  output logic      [15:0] cpu_addr_out,
  output logic             cpu_io_cycle_out,
  output logic             cpu_read_out,
  output logic             cpu_write_out,
  output logic      [15:0] isa_addr_out,
  output logic             isa_io_cycle_out,
  output logic             isa_read_out,
  output logic             isa_write_out,
  input  wire logic [1:0]  io_range_select_in,
  input  wire logic        local_device_claim_in
);
  initial begin
    {cpu_io_cycle_out, cpu_read_out, cpu_write_out} = 3'h0;
    {isa_io_cycle_out, isa_read_out, isa_write_out} = 3'h0;
    cpu_addr_out = 16'h5a5a;
    isa_addr_out = 16'ha5a5;
  end

  task automatic cycle(input logic isa, input logic io, input logic [15:0] a, input logic rd,
                       input logic wr, output logic [2:0] seen);
    @(posedge clock_in);
    if (isa) begin
      isa_addr_out <= a;
      {isa_io_cycle_out, isa_read_out, isa_write_out} <= {io, rd, wr};
    end else begin
      cpu_addr_out <= a;
      {cpu_io_cycle_out, cpu_read_out, cpu_write_out} <= {io, rd, wr};
    end
    repeat (2) @(posedge clock_in);
    #1 seen = {io_range_select_in, local_device_claim_in};
    @(posedge clock_in);
    // released address lines carry the inverse of the last value so a stale address cannot match
    cpu_addr_out <= ~cpu_addr_out;
    isa_addr_out <= ~isa_addr_out;
    {cpu_io_cycle_out, cpu_read_out, cpu_write_out} <= 3'h0;
    {isa_io_cycle_out, isa_read_out, isa_write_out} <= 3'h0;
  endtask : cycle
endmodule : io_bus_model
`default_nettype wire

// ==== testbench/programmable_io_range_decoder_bench.sv ====
`timescale 1ns/1ns
`default_nettype none
module programmable_io_range_decoder_bench import io_range_pkg::*;;
  logic        clock_in     = 1'b0;
  logic        rst_n_in     = 1'b0;
  logic [7:0]  reg_addr_in  = 8'h00;
  logic [7:0]  reg_wdata_in = 8'h00;
  logic        reg_write_in = 1'b0;
  logic        reg_read_in  = 1'b0;
  logic [7:0]  reg_rdata_out;
  logic [15:0] cpu_addr, isa_addr;
  logic        cpu_io, cpu_rd, cpu_wr, isa_io, isa_rd, isa_wr, claim;
  logic [1:0]  sel;
  int          err_total    = 0;
  int          checked      = 0;

  always #2 clock_in = ~clock_in;

  io_range_decoder dut (.clock_in(clock_in), .rst_n_in(rst_n_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_write_in(reg_write_in), .reg_read_in(reg_read_in),
    .reg_rdata_out(reg_rdata_out), .cpu_addr_in(cpu_addr), .cpu_io_cycle_in(cpu_io),
    .cpu_read_in(cpu_rd), .cpu_write_in(cpu_wr), .isa_addr_in(isa_addr), .isa_io_cycle_in(isa_io),
    .isa_read_in(isa_rd), .isa_write_in(isa_wr), .io_range_select_out(sel), .local_device_claim_out(claim));

  io_bus_model bus (.clock_in(clock_in), .cpu_addr_out(cpu_addr), .cpu_io_cycle_out(cpu_io),
    .cpu_read_out(cpu_rd), .cpu_write_out(cpu_wr), .isa_addr_out(isa_addr), .isa_io_cycle_out(isa_io),
    .isa_read_out(isa_rd), .isa_write_out(isa_wr), .io_range_select_in(sel), .local_device_claim_in(claim));

  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %0t register read %h expected %h", $time, got, exp);
    end
  endtask : cmp8

  task automatic cmp3(input logic [2:0] got, input logic [2:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %0t select and claim %b expected %b", $time, got, exp);
    end
  endtask : cmp3

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_in);
    reg_addr_in  <= a;
    reg_wdata_in <= d;
    reg_write_in <= 1'b1;
    @(posedge clock_in);
    reg_write_in <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clock_in);
    reg_addr_in <= a;
    reg_read_in <= 1'b1;
    @(posedge clock_in);
    reg_read_in <= 1'b0;
    #1 cmp8(reg_rdata_out, exp);
    @(posedge clock_in);
    #1 cmp8(reg_rdata_out, 8'h00);
  endtask : rd_reg

  task automatic set_range(input logic g, input logic [7:0] lo, hi, sm, cfg);
    logic [7:0] b;
    b = RANGE0_BASE_LOW + (g ? RANGE_STRIDE : 8'h00);
    wr_reg(b, lo);
    wr_reg(b + 8'h01, hi);
    wr_reg(b + 8'h02, sm);
    wr_reg(b + 8'h03, cfg);
  endtask : set_range

  // expected is {select range 1, select range 0, claim}
  task automatic probe(input logic isa, io, input logic [15:0] a, input logic rd, wr, input logic [2:0] exp);
    logic [2:0] seen;
    bus.cycle(isa, io, a, rd, wr, seen);
    cmp3(seen, exp);
  endtask : probe

  task automatic t_reset;
    wr_reg(8'h30, 8'hff);
    wr_reg(8'h27, 8'hff);
    for (int i = 0; i < 8; i++) rd_reg(RANGE0_BASE_LOW + 8'(i), REG_RESET);
    rd_reg(8'h30, 8'h00);
    rd_reg(8'h27, 8'h00);
    probe(1'b0, 1'b1, 16'h0000, 1'b1, 1'b0, 3'b000);
  endtask : t_reset

  task automatic t_regs;
    set_range(1'b0, 8'ha5, 8'h3c, 8'h5a, 8'h07);
    rd_reg(RANGE0_BASE_LOW, 8'ha5);
    rd_reg(RANGE0_BASE_HIGH, 8'h3c);
    rd_reg(RANGE0_SIZE_MASK, 8'h5a);
    rd_reg(RANGE0_CONFIG, 8'h07);
    probe(1'b0, 1'b1, 16'h3ca5, 1'b1, 1'b1, 3'b000);
  endtask : t_regs

  task automatic t_size;
    set_range(1'b0, 8'h00, 8'h03, 8'h03, 8'h10);
    probe(1'b0, 1'b1, 16'h0307, 1'b1, 1'b0, 3'b010);
    probe(1'b0, 1'b1, 16'h0308, 1'b1, 1'b0, 3'b000);
    wr_reg(RANGE0_SIZE_MASK, 8'h07);
    probe(1'b0, 1'b1, 16'h037f, 1'b1, 1'b0, 3'b010);
    probe(1'b0, 1'b1, 16'h0380, 1'b1, 1'b0, 3'b000);
    probe(1'b0, 1'b0, 16'h0300, 1'b1, 1'b0, 3'b000);
  endtask : t_size

  task automatic t_mask;
    for (int k = 0; k < 4; k++) begin
      wr_reg(RANGE0_SIZE_MASK, 8'h00);
      probe(1'b0, 1'b1, 16'h0300 ^ (16'h0080 << k), 1'b1, 1'b0, 3'b000);
      wr_reg(RANGE0_SIZE_MASK, 8'h08 << k);
      probe(1'b0, 1'b1, 16'h0300 ^ (16'h0080 << k), 1'b1, 1'b0, 3'b010);
    end
    wr_reg(RANGE0_SIZE_MASK, 8'h80);
    probe(1'b0, 1'b1, 16'hfb00, 1'b1, 1'b0, 3'b010);
    probe(1'b0, 1'b1, 16'h0700, 1'b1, 1'b0, 3'b000);
  endtask : t_mask

  task automatic t_dir;
    wr_reg(RANGE0_SIZE_MASK, 8'h00);
    probe(1'b0, 1'b1, 16'h0300, 1'b0, 1'b1, 3'b000);
    wr_reg(RANGE0_CONFIG, 8'h20);
    probe(1'b0, 1'b1, 16'h0300, 1'b0, 1'b1, 3'b010);
    probe(1'b0, 1'b1, 16'h0300, 1'b1, 1'b0, 3'b000);
    wr_reg(RANGE0_CONFIG, 8'h90);
    probe(1'b0, 1'b1, 16'h0300, 1'b0, 1'b1, 3'b000);
    probe(1'b0, 1'b1, 16'h0300, 1'b1, 1'b0, 3'b010);
    wr_reg(RANGE0_CONFIG, 8'hb0);
    probe(1'b0, 1'b1, 16'h0300, 1'b0, 1'b1, 3'b010);
  endtask : t_dir

  task automatic t_isa_claim;
    wr_reg(RANGE0_CONFIG, 8'h10);
    probe(1'b1, 1'b1, 16'h0300, 1'b1, 1'b0, 3'b000);
    wr_reg(RANGE0_CONFIG, 8'h58);
    probe(1'b1, 1'b1, 16'h0300, 1'b1, 1'b0, 3'b010);
    wr_reg(RANGE0_CONFIG, 8'h08);
    probe(1'b0, 1'b1, 16'h0300, 1'b1, 1'b0, 3'b001);
    probe(1'b0, 1'b1, 16'h0301, 1'b1, 1'b0, 3'b000);
    wr_reg(RANGE0_CONFIG, 8'h00);
    probe(1'b0, 1'b1, 16'h0300, 1'b1, 1'b1, 3'b000);
    set_range(1'b1, 8'h20, 8'h01, 8'h00, 8'h38);
    probe(1'b0, 1'b1, 16'h0120, 1'b0, 1'b1, 3'b101);
  endtask : t_isa_claim

  task automatic test_done;
    if (err_total == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : test_done

  initial begin
    repeat (3) @(posedge clock_in);
    rst_n_in <= 1'b1;
    repeat (3) @(posedge clock_in);
    t_reset();
    t_regs();
    t_size();
    t_mask();
    t_dir();
    t_isa_claim();
    test_done();
  end

  // the sequence needs well under two thousand cycles
  initial begin
    #20000;
    err_total++;
    test_done();
  end
endmodule : programmable_io_range_decoder_bench
`default_nettype wire
